// ### core/capture_pkg.sv
// Functional notes
// - Pre-alert policy 100b stores from start until a sequenced channel flag.
// - Pre-alert: beyond 16 conversions the oldest entries are overwritten.
// - Pre or post-alert: halt bit before full ends sequence, no more storing.
// - Post-alert policy 110b stores sixteen conversions after alert, then halts.
// - Post-alert converts from go, but stores only once a flag is raised.
// - Start burst 001b fills the buffer from go and stops when full.
// - Stop burst 000b keeps filling until the halt bit is set.
// - Stop burst: beyond 16 conversions the earliest entries are overwritten.
// - Mode 111b starts converting and summing into accumulators on go.
// - High precision ends after 16 conversions per scanned channel (32 when both are scanned) or earlier on halt.
// - Each channel has its own accumulator fed only by its results.
// - Halt of a high-precision run before ready falls marks the sum invalid.
// - In high precision a buffer read returns all zeros.
// - In high precision busy/ready changes when accumulation completes.
// - Writing 03h to a latched flag register clears those flags.
// - Conversions are paced by the chosen oscillator divided by the count.
// - Mode 110b is autonomous; host gives the first start, device the rest.
package capture_pkg;

  localparam int unsigned ADR_W   = 8;
  localparam int unsigned DATA_W  = 12;
  localparam int unsigned ENTRY_W = 16;
  localparam int unsigned DEPTH   = 16;
  localparam int unsigned PTR_W   = 4;
  localparam int unsigned CNT_W   = 5;
  localparam int unsigned ACC_W   = 16;
  localparam int unsigned DIV_W   = 8;

  localparam logic [CNT_W-1:0] BUF_FULL   = 5'h10;
  localparam logic [CNT_W-1:0] HP_ROUNDS  = 5'h10;

  // Register byte offsets.
  localparam logic [ADR_W-1:0] OFS_MODE   = 8'h00;
  localparam logic [ADR_W-1:0] OFS_SCAN   = 8'h04;
  localparam logic [ADR_W-1:0] OFS_PACE   = 8'h08;
  localparam logic [ADR_W-1:0] OFS_POLICY = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_GO     = 8'h10;
  localparam logic [ADR_W-1:0] OFS_HALT   = 8'h14;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h18;
  localparam logic [ADR_W-1:0] OFS_SUMEN  = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_ACC0   = 8'h20;
  localparam logic [ADR_W-1:0] OFS_ACC1   = 8'h24;
  localparam logic [ADR_W-1:0] OFS_CMPEN  = 8'h28;
  localparam logic [ADR_W-1:0] OFS_ALMEN  = 8'h2C;
  localparam logic [ADR_W-1:0] OFS_LOWF   = 8'h30;
  localparam logic [ADR_W-1:0] OFS_HIGHF  = 8'h34;
  localparam logic [ADR_W-1:0] OFS_BUFRD  = 8'h38;

  localparam logic [2:0] MODE_AUTO  = 3'h6;
  localparam logic [2:0] MODE_HPREC = 3'h7;
  localparam logic [2:0] POL_PRE    = 3'h4;
  localparam logic [2:0] POL_POST   = 3'h6;
  localparam logic [2:0] POL_START  = 3'h1;
  localparam logic [2:0] POL_STOP   = 3'h0;
  localparam logic [7:0] FLAG_CLEAR = 8'h03;

  localparam logic [2:0] MODE_RST   = 3'h0;
  localparam logic [1:0] SCAN_RST   = 2'h1;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h01;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RUN     = 2'b01,
    ST_CAPTURE = 2'b11
  } seq_state_t;

endpackage

// ### core/capture_ram.sv
module capture_ram
  import capture_pkg::*;
(
  // Clock.
  input  wire logic               clk,
  // Write port.
  input  wire logic               wr_en,
  input  wire logic [PTR_W-1:0]   wr_addr,
  input  wire logic [ENTRY_W-1:0] wr_data,
  // Registered read port.
  input  wire logic [PTR_W-1:0]   rd_addr,
  output logic      [ENTRY_W-1:0] rd_data_q
);

  logic [ENTRY_W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data_q <= mem[rd_addr];
  end

endmodule

// ### core/capture_ctrl.sv
module capture_ctrl
  import capture_pkg::*;
(
  // Clock and reset.
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  // Wishbone slave.
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [ADR_W-1:0]  WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  // Oscillator pins, asynchronous to the core clock.
  input  wire logic              OSC_FAST,
  input  wire logic              OSC_SLOW,
  // Converter handshake.
  output logic                   CONV_START,
  output logic                   CONV_CH,
  input  wire logic              CONV_DONE,
  input  wire logic [DATA_W-1:0] CONV_DATA,
  // Window comparator event pulses, one bit per channel.
  input  wire logic [1:0]        CMP_LOW,
  input  wire logic [1:0]        CMP_HIGH,
  // Busy/ready pin.
  output logic                   BUSY_RDY
);

  seq_state_t state_q;
  logic [2:0]         operating_mode_select_q;
  logic [1:0]         scan_channel_select_q;
  logic               oscillator_choice_q;
  logic [DIV_W-1:0]   conversion_cycle_count_q;
  logic [2:0]         buffer_capture_policy_q;
  logic [1:0]         summing_enable_q;
  logic               comparator_block_enable_bit_q;
  logic [1:0]         per_channel_alarm_enable_q;
  logic [1:0]         low_flags_q;
  logic [1:0]         high_flags_q;
  logic [ACC_W-1:0]   acc_q [2];
  logic               acc_valid_q;
  logic [CNT_W-1:0]   rounds_q;
  logic [PTR_W-1:0]   wr_ptr_q;
  logic [PTR_W-1:0]   rd_ptr_q;
  logic [CNT_W-1:0]   count_q;
  logic [CNT_W-1:0]   stored_q;
  logic [DIV_W-1:0]   div_q;
  logic [2:0]         fast_sync_q;
  logic [2:0]         slow_sync_q;
  logic [ENTRY_W-1:0] ram_rd_data;

  logic acc_strobe, wr_strobe, rd_strobe;
  logic sequence_go_bit, sequence_halt_bit, buf_pop;
  logic hp_mode, start_ok, osc_edge, pace_tick;
  logic scanned_ch, both_ch, first_ch;
  logic alert_hit, store_now, buf_full, post_done, hp_done, stop_now;
  logic [1:0] alarm_mask;

  assign acc_strobe = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_strobe  = acc_strobe && WB_WE_I && WB_SEL_I[0];
  assign rd_strobe  = acc_strobe && !WB_WE_I;
  assign sequence_go_bit   = wr_strobe && WB_ADR_I == OFS_GO && WB_DAT_I[0];
  assign sequence_halt_bit = wr_strobe && WB_ADR_I == OFS_HALT
                             && WB_DAT_I[0];
  assign hp_mode  = operating_mode_select_q == MODE_HPREC;
  assign start_ok = operating_mode_select_q == MODE_AUTO || hp_mode;
  assign buf_pop  = rd_strobe && WB_ADR_I == OFS_BUFRD && !hp_mode
                    && count_q != '0;

  // Channel scan: both bits alternate 0 then 1, else the single channel.
  assign both_ch  = &scan_channel_select_q;
  assign first_ch = scan_channel_select_q == 2'h2;
  assign scanned_ch = both_ch ? ~CONV_CH : first_ch;

  // Oscillator edges; the detector reads only the second and third stage.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fast_sync_q <= '0;
      slow_sync_q <= '0;
    end else begin
      fast_sync_q <= {fast_sync_q[1:0], OSC_FAST};
      slow_sync_q <= {slow_sync_q[1:0], OSC_SLOW};
    end
  end

  assign osc_edge = oscillator_choice_q ?
                    (slow_sync_q[1] && !slow_sync_q[2]) :
                    (fast_sync_q[1] && !fast_sync_q[2]);

  // A count of zero acts as one so the divider never stalls.
  assign pace_tick = osc_edge && div_q + 8'h01 >= conversion_cycle_count_q;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q <= '0;
    end else if (state_q == ST_IDLE || pace_tick) begin
      div_q <= '0;
    end else if (osc_edge) begin
      div_q <= div_q + 8'h01;
    end
  end

  // The host go write gives the first start; the divider gives the rest.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CONV_START <= 1'b0;
      CONV_CH    <= 1'b0;
    end else begin
      CONV_START <= 1'b0;
      if (state_q == ST_IDLE && sequence_go_bit && start_ok) begin
        CONV_START <= 1'b1;
        CONV_CH    <= first_ch;
      end else if (state_q != ST_IDLE && !stop_now && pace_tick) begin
        CONV_START <= 1'b1;
        CONV_CH    <= scanned_ch;
      end
    end
  end

  // Only channels that are scanned, alarmed and enabled raise an alert.
  assign alarm_mask = per_channel_alarm_enable_q & scan_channel_select_q
                      & {2{comparator_block_enable_bit_q}};
  assign alert_hit = |((CMP_LOW | CMP_HIGH) & alarm_mask);

  assign buf_full  = count_q == BUF_FULL;
  assign store_now = CONV_DONE && !hp_mode && !sequence_halt_bit
                     && (state_q == ST_CAPTURE ||
                         (state_q == ST_RUN &&
                          buffer_capture_policy_q != POL_POST));
  assign post_done = state_q == ST_CAPTURE && CONV_DONE
                     && stored_q + 5'h01 == BUF_FULL;
  assign hp_done   = hp_mode && CONV_DONE && state_q == ST_RUN
                     && CONV_CH == scan_channel_select_q[1]
                     && rounds_q + 5'h01 == HP_ROUNDS;

  always_comb begin
    stop_now = sequence_halt_bit;
    if (state_q == ST_RUN && !hp_mode) begin
      unique case (buffer_capture_policy_q)
        POL_PRE:   stop_now = stop_now || alert_hit;
        POL_START: stop_now = stop_now ||
                              (store_now && count_q + 5'h01 == BUF_FULL);
        default:   stop_now = stop_now;
      endcase
    end
    stop_now = stop_now || post_done || hp_done;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (sequence_go_bit && start_ok) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop_now) begin
            state_q <= ST_IDLE;
          end else if (!hp_mode && alert_hit
                       && buffer_capture_policy_q == POL_POST) begin
            state_q <= ST_CAPTURE;
          end
        end
        ST_CAPTURE: begin
          if (stop_now) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUSY_RDY <= 1'b0;
    end else begin
      BUSY_RDY <= (state_q == ST_IDLE && sequence_go_bit && start_ok)
                  || (state_q != ST_IDLE && !stop_now);
    end
  end

  // Ring buffer: when full, a new entry pushes the oldest one out.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      stored_q <= '0;
    end else if (state_q == ST_IDLE && sequence_go_bit && start_ok) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      stored_q <= '0;
    end else begin
      if (store_now) begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
        stored_q <= stored_q + 5'h01;
      end
      if (store_now && buf_full) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end else if (store_now && !buf_pop) begin
        count_q <= count_q + 5'h01;
      end else if (buf_pop && !store_now) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
        count_q  <= count_q - 5'h01;
      end else if (buf_pop) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
    end
  end

  capture_ram u_ram (
    .clk       (CORE_CLK),
    .wr_en     (store_now),
    .wr_addr   (wr_ptr_q),
    .wr_data   ({3'h0, CONV_CH, CONV_DATA}),
    .rd_addr   (rd_ptr_q),
    .rd_data_q (ram_rd_data)
  );

  // Per-channel accumulators; each result lands only in its own channel.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_q[0]    <= '0;
      acc_q[1]    <= '0;
      acc_valid_q <= 1'b0;
      rounds_q    <= '0;
    end else if (state_q == ST_IDLE && sequence_go_bit && hp_mode) begin
      acc_q[0]    <= '0;
      acc_q[1]    <= '0;
      acc_valid_q <= 1'b0;
      rounds_q    <= '0;
    end else if (hp_mode && state_q == ST_RUN) begin
      if (sequence_halt_bit) begin
        acc_valid_q <= 1'b0;
      end else if (CONV_DONE) begin
        if (summing_enable_q[CONV_CH]) begin
          acc_q[CONV_CH] <= acc_q[CONV_CH] + {4'h0, CONV_DATA};
        end
        if (CONV_CH == scan_channel_select_q[1]) begin
          rounds_q <= rounds_q + 5'h01;
        end
        if (hp_done) begin
          acc_valid_q <= 1'b1;
        end
      end
    end
  end

  // Configuration and latched flags; a new event wins over a clear.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      operating_mode_select_q       <= MODE_RST;
      scan_channel_select_q         <= SCAN_RST;
      oscillator_choice_q           <= 1'b0;
      conversion_cycle_count_q      <= DIV_RST;
      buffer_capture_policy_q       <= POL_STOP;
      summing_enable_q              <= '0;
      comparator_block_enable_bit_q <= 1'b0;
      per_channel_alarm_enable_q    <= '0;
      low_flags_q                   <= '0;
      high_flags_q                  <= '0;
    end else begin
      if (wr_strobe) begin
        unique case (WB_ADR_I)
          OFS_MODE:   operating_mode_select_q <= WB_DAT_I[2:0];
          OFS_SCAN:   scan_channel_select_q   <= WB_DAT_I[1:0];
          OFS_PACE: begin
            conversion_cycle_count_q <= WB_DAT_I[7:0];
            oscillator_choice_q      <= WB_DAT_I[8];
          end
          OFS_POLICY: buffer_capture_policy_q <= WB_DAT_I[2:0];
          OFS_SUMEN:  summing_enable_q        <= WB_DAT_I[1:0];
          OFS_CMPEN:  comparator_block_enable_bit_q <= WB_DAT_I[0];
          OFS_ALMEN:  per_channel_alarm_enable_q    <= WB_DAT_I[1:0];
          default: ;
        endcase
      end
      if (wr_strobe && WB_ADR_I == OFS_LOWF
          && WB_DAT_I[7:0] == FLAG_CLEAR) begin
        low_flags_q <= CMP_LOW & alarm_mask;
      end else begin
        low_flags_q <= low_flags_q | (CMP_LOW & alarm_mask);
      end
      if (wr_strobe && WB_ADR_I == OFS_HIGHF
          && WB_DAT_I[7:0] == FLAG_CLEAR) begin
        high_flags_q <= CMP_HIGH & alarm_mask;
      end else begin
        high_flags_q <= high_flags_q | (CMP_HIGH & alarm_mask);
      end
    end
  end

  // Single-cycle ack; unmapped offsets answer with zero.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= acc_strobe;
      WB_DAT_O <= '0;
      if (rd_strobe) begin
        unique case (WB_ADR_I)
          OFS_MODE:   WB_DAT_O <= {29'h0, operating_mode_select_q};
          OFS_SCAN:   WB_DAT_O <= {30'h0, scan_channel_select_q};
          OFS_PACE:   WB_DAT_O <= {23'h0, oscillator_choice_q,
                                   conversion_cycle_count_q};
          OFS_POLICY: WB_DAT_O <= {29'h0, buffer_capture_policy_q};
          OFS_STATUS: WB_DAT_O <= {22'h0, acc_valid_q, count_q,
                                   state_q, 1'b0, BUSY_RDY};
          OFS_SUMEN:  WB_DAT_O <= {30'h0, summing_enable_q};
          OFS_ACC0:   WB_DAT_O <= {16'h0, acc_q[0]};
          OFS_ACC1:   WB_DAT_O <= {16'h0, acc_q[1]};
          OFS_CMPEN:  WB_DAT_O <= {31'h0, comparator_block_enable_bit_q};
          OFS_ALMEN:  WB_DAT_O <= {30'h0, per_channel_alarm_enable_q};
          OFS_LOWF:   WB_DAT_O <= {30'h0, low_flags_q};
          OFS_HIGHF:  WB_DAT_O <= {30'h0, high_flags_q};
          OFS_BUFRD: begin
            if (!hp_mode && count_q != '0) begin
              WB_DAT_O <= {16'h0, ram_rd_data};
            end else begin
              WB_DAT_O <= '0;
            end
          end
          default:    WB_DAT_O <= '0;
        endcase
      end
    end
  end

endmodule

// ### testbench/capture_ctrl_chk.sv
module capture_ctrl_chk (
  // Clock and reset.
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  // Register bus.
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // Converter handshake and busy pin.
  input wire logic        CONV_START,
  input wire logic        CONV_CH,
  input wire logic        BUSY_RDY
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence

  sequence s_start;
    CONV_START ##1 !CONV_START;
  endsequence

  chk_ack_follows_req: assert property (s_req |=> WB_ACK_O)
    else $error("ack did not follow a taken request");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  chk_ack_has_cause: assert property
    ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without a request");
  chk_dat_quiet: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data not zero outside ack");
  chk_start_pulse: assert property (CONV_START |-> s_start)
    else $error("conversion start longer than one cycle");
  chk_start_busy: assert property (CONV_START |-> BUSY_RDY)
    else $error("conversion started while not busy");
  chk_busy_rise: assert property ($rose(BUSY_RDY) |-> CONV_START)
    else $error("busy rose without the first start");
  chk_ch_with_start: assert property ($changed(CONV_CH) |-> CONV_START)
    else $error("channel changed between starts");
endmodule

// ### testbench/conv_model.sv
module conv_model (
  // Converter handshake.
  input  wire logic   clk,
  input  wire logic   start,
  input  wire logic   ch,
  input  wire logic   slow,
  output logic        done = 1'b0,
  output logic [11:0] data = 12'h000,
  // Free-running oscillators.
  output logic        osc_fast = 1'b0,
  output logic        osc_slow = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] n      = 8'h00;
  logic [2:0] wait_c = 3'h0;
  logic       pend   = 1'b0;
  logic       pch    = 1'b0;

  // Edges fall mid-cycle, so the core must resynchronise them.
  always #80 osc_fast = ~osc_fast;
  always #320 osc_slow = ~osc_slow;

  // Data is inverted on every edge except start and done edges, so stale values match on alternate cycles.
  always @(posedge clk) begin
    done <= 1'b0;
    if (start) begin
      pend   <= 1'b1;
      pch    <= ch;
      wait_c <= slow ? 3'h5 : 3'h1;
    end else if (pend && wait_c == 3'h0) begin
      pend <= 1'b0;
      done <= 1'b1;
      data <= {pch, 3'h0, n};
      n    <= n + 8'h01;
    end else begin
      wait_c <= wait_c - 3'h1;
      data   <= ~data;
    end
  end
endmodule

// ### testbench/autonomous_capture_and_accumulate_tb_top.sv
`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module autonomous_capture_and_accumulate_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import capture_pkg::*;
  logic        clk  = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc  = 1'b0;
  logic        stb  = 1'b0;
  logic        we   = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack, osc_f, osc_s, cstart, cch, cdone, busy;
  logic [11:0] cdata;
  logic [1:0]  cmp_lo = 2'h0;
  logic [1:0]  cmp_hi = 2'h0;
  logic        slow = 1'b0;
  logic [15:0] q[$];
  int          stq[$];
  int          cyc_n = 0;
  int          mismatches = 0;
  int          compares = 0;

  always #10 clk = ~clk;

  capture_ctrl u_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .OSC_FAST(osc_f), .OSC_SLOW(osc_s),
    .CONV_START(cstart), .CONV_CH(cch), .CONV_DONE(cdone),
    .CONV_DATA(cdata), .CMP_LOW(cmp_lo), .CMP_HIGH(cmp_hi),
    .BUSY_RDY(busy)
  );

  conv_model u_far (
    .clk(clk), .start(cstart), .ch(cch), .slow(slow), .done(cdone),
    .data(cdata), .osc_fast(osc_f), .osc_slow(osc_s)
  );

  always @(posedge clk) begin
    cyc_n++;
    if (cdone)
      q.push_back({3'h0, cch, cdata});
    if (cstart)
      stq.push_back(cyc_n);
  end

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic give_up();
    mismatches++;
    $display("[FAIL] wait expected done seen timeout");
    final_report();
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
      give_up();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    `CHK(nm, e, r)
  endtask

  // A positive count waits for results, zero waits for the sequence end.
  task automatic wait_for(input int k);
    int n;
    n = 0;
    while ((k > 0 ? q.size() < k : busy !== 1'b0) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
      give_up();
  endtask

  task automatic go();
    q.delete();
    stq.delete();
    wr(OFS_GO, 32'h1);
    `CHK("busy", 1'b1, busy)
  endtask

  task automatic pop(input int first, input int k);
    for (int i = 0; i < k; i++) begin
      rd_chk("buffer", OFS_BUFRD, {16'h0, q[first + i]});
    end
    rd_chk("buffer end", OFS_BUFRD, 32'h0);
  endtask

  task automatic pulse(input logic [1:0] lo, input logic [1:0] hi);
    @(posedge clk);
    cmp_lo <= lo;
    cmp_hi <= hi;
    @(posedge clk);
    cmp_lo <= 2'h0;
    cmp_hi <= 2'h0;
  endtask

  initial begin
    logic [31:0] r;
    logic [15:0] s0, s1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("mode", OFS_MODE, {29'h0, MODE_RST});
    rd_chk("scan", OFS_SCAN, {30'h0, SCAN_RST});
    rd_chk("pace", OFS_PACE, {24'h0, DIV_RST});
    rd_chk("unmapped", 8'hFC, 32'h0);
    wr(OFS_MODE, {29'h0, MODE_AUTO});
    wr(OFS_SCAN, 32'h3);
    wr(OFS_PACE, 32'h2);
    wr(OFS_CMPEN, 32'h1);
    wr(OFS_ALMEN, 32'h3);
    wr(OFS_POLICY, {29'h0, POL_START});
    go();
    wait_for(0);
    `CHK("start burst count", 16, q.size())
    `CHK("start spacing", 16, stq[2] - stq[1])
    for (int i = 0; i < 16; i++) `CHK("channel", i[0], q[i][12])
    pop(0, 16);
    wr(OFS_POLICY, {29'h0, POL_STOP});
    go();
    wait_for(20);
    wr(OFS_HALT, 32'h1);
    wait_for(0);
    `CHK("stop burst count", 20, q.size())
    pop(4, 16);
    wr(OFS_POLICY, {29'h0, POL_PRE});
    go();
    wait_for(18);
    pulse(2'h0, 2'h2);
    wait_for(0);
    `CHK("pre-alert count", 18, q.size())
    pop(2, 16);
    rd_chk("high flags", OFS_HIGHF, 32'h2);
    wr(OFS_HIGHF, {24'h0, FLAG_CLEAR});
    rd_chk("high flags", OFS_HIGHF, 32'h0);
    wr(OFS_POLICY, {29'h0, POL_POST});
    go();
    wait_for(3);
    pulse(2'h1, 2'h0);
    wait_for(0);
    `CHK("post-alert count", 19, q.size())
    pop(3, 16);
    rd_chk("low flags", OFS_LOWF, 32'h1);
    wr(OFS_LOWF, {24'h0, FLAG_CLEAR});
    rd_chk("low flags", OFS_LOWF, 32'h0);
    go();
    wait_for(1);
    pulse(2'h1, 2'h0);
    wait_for(3);
    wr(OFS_HALT, 32'h1);
    wait_for(0);
    pop(1, 2);
    wr(OFS_HALT, 32'h1);
    wr(OFS_MODE, {29'h0, MODE_HPREC});
    wr(OFS_SUMEN, 32'h3);
    wr(OFS_PACE, 32'h4);
    slow <= 1'b1;
    go();
    wait_for(32);
    repeat (2) @(posedge clk);
    `CHK("ready after sum", 1'b0, busy)
    `CHK("summed count", 32, q.size())
    `CHK("slow spacing", 32, stq[2] - stq[1])
    s0 = 16'h0;
    s1 = 16'h0;
    for (int i = 0; i < 32; i++) begin
      if (q[i][12])
        s1 += {4'h0, q[i][11:0]};
      else
        s0 += {4'h0, q[i][11:0]};
    end
    rd_chk("sum ch0", OFS_ACC0, {16'h0, s0});
    rd_chk("sum ch1", OFS_ACC1, {16'h0, s1});
    wb(1'b0, OFS_STATUS, 32'h0, r);
    `CHK("sum valid", 1'b1, r[9])
    rd_chk("summing buffer", OFS_BUFRD, 32'h0);
    go();
    wait_for(3);
    wr(OFS_HALT, 32'h1);
    wait_for(0);
    wb(1'b0, OFS_STATUS, 32'h0, r);
    `CHK("sum valid", 1'b0, r[9])
    `CHK("aborted count", 3, q.size())
    final_report();
  end
endmodule

bind capture_ctrl capture_ctrl_chk u_chk (
  .CORE_CLK  (CORE_CLK),
  .RST_N     (RST_N),
  .WB_CYC_I  (WB_CYC_I),
  .WB_STB_I  (WB_STB_I),
  .WB_DAT_O  (WB_DAT_O),
  .WB_ACK_O  (WB_ACK_O),
  .CONV_START(CONV_START),
  .CONV_CH   (CONV_CH),
  .BUSY_RDY  (BUSY_RDY)
);
